// [verilog/ptsm_pkg.sv]
// Constants and types shared by the pulse-per-second time synchroniser.
package ptsm_pkg;

	// ****************************************************************
	// Time base
	// ****************************************************************
	localparam int unsigned CLK_PERIOD_NS   = 8;
	localparam int unsigned PULSE_PERIOD_NS = 1000000000;
	localparam int unsigned OUT_PULSE_NS    = 100000;
	localparam logic [29:0] NS_PER_SEC      = 30'h3b9aca00;
	localparam logic [29:0] NS_HALF_SEC     = 30'h1dcd6500;
	localparam logic [29:0] NS_STEP         = 30'h8;
	localparam logic [31:0] THR_DEFAULT_NS  = 32'h254;

	// ****************************************************************
	// Selector and state codes
	// ****************************************************************
	typedef enum logic [2:0] {
		sel_in_none,
		sel_in_serial_pulse,
		sel_in_host,
		sel_in_internal,
		sel_in_aux
	} ptsm_in_t;

	typedef enum logic [2:0] {
		sel_out_none,
		sel_out_repeat_pulse,
		sel_out_loop,
		sel_out_host,
		sel_out_internal
	} ptsm_out_t;

	typedef enum logic [1:0] {
		st_free,
		st_acquire,
		st_locked
	} ptsm_state_t;

	// Counter indices.
	localparam int unsigned CNT_TOTAL  = 0;
	localparam int unsigned CNT_BAD    = 1;
	localparam int unsigned CNT_MISSED = 2;
	localparam int unsigned CNT_FAIL   = 3;
	localparam int unsigned CNT_RESYNC = 4;
	localparam int unsigned CNT_NUM    = 5;

endpackage

// [verilog/ptsm_stat_ctr.sv]
// Saturating statistics counter with clear.
`timescale 1ns/1ps
module ptsm_stat_ctr #(
	parameter int unsigned W = 32
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic         i_clr,
	input  wire logic         i_inc,
	output logic [W-1:0]      o_cnt
);
	logic [W-1:0] cnt_ff;

	// An event in the cycle of a clear is kept: it counts as one.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_ff <= '0;
		end else if (i_clr) begin
			cnt_ff <= i_inc ? W'(1) : '0;
		end else if (i_inc && (cnt_ff != '1)) begin
			cnt_ff <= cnt_ff + W'(1);
		end
	end

	assign o_cnt = cnt_ff;
endmodule // ptsm_stat_ctr

// [verilog/ptsm_time_sync.sv]
// Time-of-day clock with selectable pulse discipline and sync output.
`timescale 1ns/1ps
module ptsm_time_sync
	import ptsm_pkg::*;
#(
	parameter int unsigned SEC_CYCLES = PULSE_PERIOD_NS / CLK_PERIOD_NS,
	parameter int unsigned OUT_PULSE_CYC = OUT_PULSE_NS / CLK_PERIOD_NS,
	parameter int unsigned CNT_W = 32
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic             i_load_time,
	input  wire logic             i_full_reset,
	input  wire logic [31:0]      i_host_sec,
	input  wire logic [29:0]      i_host_ns,
	input  wire logic             i_host_pps,
	input  wire logic             i_sel_wr,
	input  wire ptsm_in_t         i_sel_in,
	input  wire ptsm_out_t        i_sel_out,
	input  wire logic             i_thr_wr,
	input  wire logic [31:0]      i_thr_ns,
	input  wire logic             i_clear_stats,
	input  wire logic             i_pps_in,
	output logic                  o_pps_out,
	output logic                  o_pps_out_oe_n,
	output logic [31:0]           o_tod_sec,
	output logic [29:0]           o_tod_ns,
	output logic                  o_synced,
	output logic                  o_free_running,
	output ptsm_in_t              o_sel_in,
	output ptsm_out_t             o_sel_out,
	output logic [31:0]           o_thr_ns,
	output logic [CNT_W-1:0]      o_cnt_total,
	output logic [CNT_W-1:0]      o_cnt_bad,
	output logic [CNT_W-1:0]      o_cnt_missed,
	output logic [CNT_W-1:0]      o_cnt_fail,
	output logic [CNT_W-1:0]      o_cnt_resync
);
	localparam logic [31:0] HALF_CYC = 32'(SEC_CYCLES / 2);
	localparam logic [31:0] MISS_CYC = 32'(SEC_CYCLES + SEC_CYCLES / 2);
	localparam logic [31:0] OPW_CYC  = 32'(OUT_PULSE_CYC);

	// ****************************************************************
	// Input synchroniser and source selection
	// ****************************************************************
	logic        pps_meta_ff;
	logic        pps_sync_ff;
	logic        src_lvl_ff;
	logic        src_lvl;
	logic        src_edge;
	ptsm_in_t    sel_in_ff;
	ptsm_out_t   sel_out_ff;
	logic [31:0] thr_ff;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pps_meta_ff <= 1'b0;
			pps_sync_ff <= 1'b0;
		end else begin
			pps_meta_ff <= i_pps_in;
			pps_sync_ff <= pps_meta_ff;
		end
	end

	// Only the serial pulse and the internal host reference discipline.
	always_comb begin
		case (sel_in_ff)
			sel_in_serial_pulse: src_lvl = pps_sync_ff;
			sel_in_internal:     src_lvl = i_host_pps;
			default:             src_lvl = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			src_lvl_ff <= 1'b0;
		end else begin
			src_lvl_ff <= src_lvl;
		end
	end

	assign src_edge = src_lvl & ~src_lvl_ff;

	// ****************************************************************
	// Configuration
	// ****************************************************************
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sel_in_ff  <= sel_in_serial_pulse;
			sel_out_ff <= sel_out_none;
		end else if (i_full_reset) begin
			sel_in_ff  <= sel_in_serial_pulse;
			sel_out_ff <= sel_out_none;
		end else if (i_sel_wr) begin
			sel_in_ff  <= i_sel_in;
			sel_out_ff <= i_sel_out;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			thr_ff <= THR_DEFAULT_NS;
		end else if (i_thr_wr) begin
			thr_ff <= i_thr_ns;
		end
	end

	// ****************************************************************
	// Pulse qualification
	// ****************************************************************
	logic        src_active;
	logic [31:0] since_ff;
	logic        pulse_ok;
	logic        pulse_bad;
	logic        pulse_miss;
	logic        late;
	logic [29:0] err_mag;
	logic        in_thr;
	logic [31:0] tod_sec_ff;
	logic [29:0] tod_ns_ff;
	assign src_active = (sel_in_ff == sel_in_serial_pulse) ||
	                    (sel_in_ff == sel_in_internal);
	assign pulse_bad  = src_active && src_edge && (since_ff < HALF_CYC);
	assign pulse_ok   = src_active && src_edge && !pulse_bad;
	assign pulse_miss = src_active && !src_edge && (since_ff >= MISS_CYC);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			since_ff <= 32'h0;
		end else if (pulse_ok || !src_active) begin
			since_ff <= 32'h0;
		end else if (pulse_miss) begin
			since_ff <= HALF_CYC;
		end else if (since_ff != 32'hffffffff) begin
			since_ff <= since_ff + 32'h1;
		end
	end

	// Phase error: below half a second the pulse is late and the local clock ahead.
	assign late    = tod_ns_ff < NS_HALF_SEC;
	assign err_mag = late ? tod_ns_ff : (NS_PER_SEC - tod_ns_ff);
	assign in_thr  = {2'h0, err_mag} <= thr_ff;

	// ****************************************************************
	// Time of day
	// ****************************************************************
	logic        roll;
	assign roll = (tod_ns_ff + NS_STEP) >= NS_PER_SEC;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			tod_sec_ff <= 32'h0;
			tod_ns_ff  <= 30'h0;
		end else if (i_load_time || i_full_reset) begin
			tod_sec_ff <= i_host_sec;
			tod_ns_ff  <= i_host_ns;
		end else if (pulse_ok && !in_thr) begin
			tod_ns_ff <= NS_STEP;
			if (!late) begin
				tod_sec_ff <= tod_sec_ff + 32'h1;
			end
		end else if (roll) begin
			tod_ns_ff  <= tod_ns_ff + NS_STEP - NS_PER_SEC;
			tod_sec_ff <= tod_sec_ff + 32'h1;
		end else begin
			tod_ns_ff <= tod_ns_ff + NS_STEP;
		end
	end

	// ****************************************************************
	// Synchronisation state
	// ****************************************************************
	ptsm_state_t state_ff;
	logic        fail_ev;
	logic        resync_ev;
	assign fail_ev   = (state_ff == st_locked) &&
	                   (!src_active || (pulse_ok && !in_thr));
	assign resync_ev = pulse_ok && !in_thr;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_ff <= st_acquire;
		end else if (i_full_reset || i_load_time) begin
			state_ff <= st_acquire;
		end else begin
			case (state_ff)
				st_free: begin
					if (src_active) begin
						state_ff <= st_acquire;
					end
				end
				st_acquire: begin
					if (!src_active) begin
						state_ff <= st_free;
					end else if (pulse_ok && in_thr) begin
						state_ff <= st_locked;
					end
				end
				st_locked: begin
					if (!src_active) begin
						state_ff <= st_free;
					end else if (pulse_ok && !in_thr) begin
						state_ff <= st_acquire;
					end
				end
				default: state_ff <= st_acquire;
			endcase
		end
	end

	// ****************************************************************
	// Synchronisation output
	// ****************************************************************
	logic [31:0] opw_ff;
	logic        out_lvl;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			opw_ff <= 32'h0;
		end else if (roll && !i_load_time && !i_full_reset) begin
			opw_ff <= OPW_CYC;
		end else if (opw_ff != 32'h0) begin
			opw_ff <= opw_ff - 32'h1;
		end
	end

	always_comb begin
		case (sel_out_ff)
			sel_out_repeat_pulse: out_lvl = pps_sync_ff;
			sel_out_loop:         out_lvl = src_lvl;
			sel_out_internal:     out_lvl = opw_ff != 32'h0;
			default:              out_lvl = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_pps_out      <= 1'b0;
			o_pps_out_oe_n <= 1'b1;
		end else begin
			o_pps_out      <= out_lvl;
			o_pps_out_oe_n <= (sel_out_ff == sel_out_none) ||
			                  (sel_out_ff == sel_out_host);
		end
	end

	// ****************************************************************
	// Statistics
	// ****************************************************************
	logic [CNT_NUM-1:0] cnt_inc;
	logic [CNT_W-1:0]   cnt_val [CNT_NUM];
	assign cnt_inc[CNT_TOTAL]  = src_active && src_edge;
	assign cnt_inc[CNT_BAD]    = pulse_bad;
	assign cnt_inc[CNT_MISSED] = pulse_miss;
	assign cnt_inc[CNT_FAIL]   = fail_ev;
	assign cnt_inc[CNT_RESYNC] = resync_ev;

	for (genvar g = 0; g < CNT_NUM; g++) begin : g_cnt
		ptsm_stat_ctr #(
			.W (CNT_W)
		) u_ctr (
			.i_clk (i_clk),
			.i_rst (i_rst),
			.i_clr (i_clear_stats),
			.i_inc (cnt_inc[g]),
			.o_cnt (cnt_val[g])
		);
	end

	assign o_cnt_total  = cnt_val[CNT_TOTAL];
	assign o_cnt_bad    = cnt_val[CNT_BAD];
	assign o_cnt_missed = cnt_val[CNT_MISSED];
	assign o_cnt_fail   = cnt_val[CNT_FAIL];
	assign o_cnt_resync = cnt_val[CNT_RESYNC];

	// ****************************************************************
	// Status
	// ****************************************************************
	assign o_tod_sec      = tod_sec_ff;
	assign o_tod_ns       = tod_ns_ff;
	assign o_synced       = state_ff == st_locked;
	assign o_free_running = state_ff == st_free;
	assign o_sel_in       = sel_in_ff;
	assign o_sel_out      = sel_out_ff;
	assign o_thr_ns       = thr_ff;
endmodule // ptsm_time_sync

// [verif/ptsm_pps_src.sv]
// Reference pulse-per-second source model.
`timescale 1ns/1ps
module ptsm_pps_src #(
	parameter int unsigned PER = 1000
) (
	input  wire logic i_clk,
	input  wire logic i_en,
	input  wire logic i_force,
	output logic      o_pps
);
	int unsigned cnt_ff;

	always_ff @(posedge i_clk) begin
		if (!i_en || cnt_ff == PER - 1) begin
			cnt_ff <= 0;
		end else begin
			cnt_ff <= cnt_ff + 1;
		end
	end

	// One pulse a period; the receiver idles low when off.
	assign o_pps = i_force | (i_en && cnt_ff >= PER - 4);
endmodule // ptsm_pps_src

// [verif/ptsm_time_sync_monitor.sv]
// Port checks for the time synchroniser.
`timescale 1ns/1ps
module ptsm_time_sync_monitor
	import ptsm_pkg::*;
(
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic        i_load_time,
	input wire logic        i_full_reset,
	input wire logic [29:0] i_host_ns,
	input wire logic        i_sel_wr,
	input wire ptsm_in_t    i_sel_in,
	input wire ptsm_out_t   i_sel_out,
	input wire logic        i_pps_in,
	input wire logic        o_pps_out,
	input wire logic        o_pps_out_oe_n,
	input wire logic [29:0] o_tod_ns,
	input wire logic        o_synced,
	input wire logic        o_free_running,
	input wire ptsm_in_t    o_sel_in,
	input wire ptsm_out_t   o_sel_out
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_rep_hi;
		o_sel_out == sel_out_repeat_pulse && i_pps_in;
	endsequence
	sequence s_idle;
		o_sel_in inside {sel_in_none, sel_in_host, sel_in_aux}
		&& !i_load_time && !i_full_reset;
	endsequence
	AST_LOAD: assert property (
		i_load_time |=> o_tod_ns == $past(i_host_ns))
		else $error("time of day not loaded");
	AST_ADV: assert property (
		o_sel_in == sel_in_none && !i_load_time && !i_full_reset
		&& !i_sel_wr && o_tod_ns < NS_PER_SEC - NS_STEP
		|=> o_tod_ns == $past(o_tod_ns) + NS_STEP)
		else $error("time of day did not advance");
	AST_FULL: assert property (
		i_full_reset |=> o_sel_in == sel_in_serial_pulse
		&& o_sel_out == sel_out_none && !o_synced)
		else $error("full reset left selectors");
	AST_OE: assert property (
		o_sel_out inside {sel_out_none, sel_out_host}
		|=> o_pps_out_oe_n)
		else $error("output driven while off");
	AST_DRV: assert property (
		o_sel_out inside {sel_out_repeat_pulse, sel_out_loop,
		sel_out_internal} |=> !o_pps_out_oe_n)
		else $error("output not driven");
	AST_IDLE: assert property (
		s_idle [*2] |-> o_free_running && !o_synced)
		else $error("idle input not free running");
	AST_SEL: assert property (
		i_sel_wr && !i_full_reset |=> o_sel_in == $past(i_sel_in)
		&& o_sel_out == $past(i_sel_out))
		else $error("selector write lost");
	AST_REP: assert property (
		s_rep_hi [*6] |-> o_pps_out)
		else $error("pulse not repeated");
endmodule // ptsm_time_sync_monitor

bind ptsm_time_sync ptsm_time_sync_monitor i_ptsm_time_sync_monitor (.*);

// [verif/ptsm_time_sync_tb_top.sv]
// Self-checking bench for the time synchroniser.
`timescale 1ns/1ps
module ptsm_time_sync_tb_top import ptsm_pkg::*; ;
	logic i_clk, i_rst, i_load_time, i_full_reset, i_host_pps;
	logic i_sel_wr, i_thr_wr, i_clear_stats, i_pps_in, pps_en, frc;
	logic [31:0] i_host_sec, i_thr_ns, o_tod_sec, o_thr_ns;
	logic [31:0] o_cnt_total, o_cnt_bad, o_cnt_missed, o_cnt_fail;
	logic [31:0] o_cnt_resync;
	logic [29:0] i_host_ns, o_tod_ns;
	logic        o_pps_out, o_pps_out_oe_n, o_synced, o_free_running;
	ptsm_in_t    i_sel_in, o_sel_in;
	ptsm_out_t   i_sel_out, o_sel_out;
	int          n_errors, checks_done, hi;

	ptsm_time_sync #(.SEC_CYCLES(1000), .OUT_PULSE_CYC(10))
		i_ptsm_time_sync (.*);
	ptsm_pps_src #(.PER(1000)) i_ptsm_pps_src (.i_clk(i_clk),
		.i_en(pps_en), .i_force(frc), .o_pps(i_pps_in));

	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch t=%0t got %0h exp %0h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	task automatic sel(input ptsm_in_t a, input ptsm_out_t b);
		@(posedge i_clk);
		i_sel_in <= a;
		i_sel_out <= b;
		i_sel_wr <= 1'b1;
		@(posedge i_clk);
		i_sel_wr <= 1'b0;
		cyc(2);
	endtask

	task automatic load(input logic f, input logic [31:0] s,
		input logic [29:0] ns);
		@(posedge i_clk);
		i_host_sec <= s;
		i_host_ns <= ns;
		i_load_time <= !f;
		i_full_reset <= f;
		@(posedge i_clk);
		i_load_time <= 1'b0;
		i_full_reset <= 1'b0;
		#1;
		chk({o_tod_sec, 2'h0, o_tod_ns}, {s, 2'h0, ns});
	endtask

	task automatic thr(input logic [31:0] v);
		@(posedge i_clk);
		i_thr_ns <= v;
		i_thr_wr <= 1'b1;
		@(posedge i_clk);
		i_thr_wr <= 1'b0;
		#1;
		chk(o_thr_ns, v);
	endtask

	task automatic t_reset;
		chk(o_sel_in, sel_in_serial_pulse);
		chk(o_sel_out, sel_out_none);
		chk(o_pps_out_oe_n, 1'b1);
		chk(o_thr_ns, THR_DEFAULT_NS);
		load(1'b0, 32'h5, NS_PER_SEC - 30'h10);
		cyc(2);
		chk({o_tod_sec, 2'h0, o_tod_ns}, {32'h6, 32'h0});
	endtask

	task automatic t_lock;
		thr(32'h4000);
		@(posedge i_clk);
		pps_en <= 1'b1;
		cyc(2200);
		chk(o_synced, 1'b1);
		chk(o_cnt_resync, 32'h0);
		@(posedge i_clk);
		frc <= 1'b1;
		repeat (3) @(posedge i_clk);
		frc <= 1'b0;
		cyc(6);
		chk({o_cnt_total, o_cnt_bad}, {32'h3, 32'h1});
		thr(32'hfa0);
		cyc(900);
		chk({o_synced, o_cnt_fail}, {1'b0, 32'h1});
		chk(o_cnt_resync, 32'h1);
		@(posedge i_clk);
		pps_en <= 1'b0;
		cyc(1600);
		chk(o_cnt_missed, 32'h1);
	endtask

	task automatic t_sel;
		sel(sel_in_none, sel_out_loop);
		chk({o_free_running, o_synced}, 2'h2);
		@(posedge i_clk);
		i_host_pps <= 1'b1;
		sel(sel_in_internal, sel_out_loop);
		chk(o_pps_out, 1'b1);
		@(posedge i_clk);
		i_host_pps <= 1'b0;
		cyc(3);
		chk(o_pps_out, 1'b0);
		sel(sel_in_none, sel_out_repeat_pulse);
		@(posedge i_clk);
		frc <= 1'b1;
		cyc(6);
		chk(o_pps_out, 1'b1);
		@(posedge i_clk);
		frc <= 1'b0;
		cyc(6);
		chk(o_pps_out, 1'b0);
		sel(sel_in_host, sel_out_host);
		chk({o_free_running, o_pps_out_oe_n}, 2'h3);
		sel(sel_in_aux, sel_out_none);
		chk(o_free_running, 1'b1);
	endtask

	task automatic t_master;
		sel(sel_in_none, sel_out_internal);
		chk(o_pps_out_oe_n, 1'b0);
		load(1'b0, 32'h9, NS_PER_SEC - 30'h50);
		hi = 0;
		repeat (40) begin
			cyc(1);
			hi += o_pps_out;
		end
		chk(hi, 10);
	endtask

	task automatic t_full;
		sel(sel_in_internal, sel_out_loop);
		load(1'b1, 32'h7, 30'h0);
		chk(o_sel_in, sel_in_serial_pulse);
		chk(o_sel_out, sel_out_none);
		cyc(1);
		chk(o_pps_out_oe_n, 1'b1);
		sel(sel_in_serial_pulse, sel_out_repeat_pulse);
		chk(o_sel_out, sel_out_repeat_pulse);
		@(posedge i_clk);
		i_clear_stats <= 1'b1;
		@(posedge i_clk);
		i_clear_stats <= 1'b0;
		cyc(1);
		chk({o_cnt_total, o_cnt_fail}, 64'h0);
	endtask

	task automatic test_done;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		{i_rst, i_load_time, i_full_reset, i_host_pps} = 4'h8;
		{i_sel_wr, i_thr_wr, i_clear_stats, pps_en, frc} = 5'h0;
		{i_host_sec, i_host_ns, i_thr_ns} = '0;
		i_sel_in = sel_in_serial_pulse;
		i_sel_out = sel_out_none;
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		cyc(1);
		t_reset;
		t_lock;
		t_sel;
		t_master;
		t_full;
		test_done;
	end

	initial begin
		repeat (20000) @(posedge i_clk);
		n_errors++;
		test_done;
	end
endmodule // ptsm_time_sync_tb_top
